/* shared/usb_frame_defs.svh */
`ifndef USB_FRAME_DEFS_SVH
`define USB_FRAME_DEFS_SVH

// Register byte offsets on the Avalon slave.
`define OFS_IRQ_STATUS 8'h44
`define OFS_FRAME_NUMBER 8'h48
`define OFS_DEV_ADDR 8'h4C

// Field positions of the event status word.
`define IRQ_SOF_BIT 9
`define IRQ_MISS_BIT 8
`define IRQ_L1_BIT 7
`define IRQ_DIR_BIT 4

// Field positions of the frame number word and the address word.
`define FNR_DP_BIT 15
`define FNR_DM_BIT 14
`define FNR_LOCK_BIT 13
`define DADDR_EF_BIT 7

// Reset value of the address word.
`define DADDR_RESET 32'h0000_0000

// Timing: clock rate and the two bus-idle intervals.
`define CLK_FREQ_HZ 25000000
`define SOF_PERIOD_US 1000
`define IDLE_SUSPEND_US 3000
`define SOF_WAIT_CYC ((`CLK_FREQ_HZ / 1000000) * `SOF_PERIOD_US)
`define IDLE_WAIT_CYC ((`CLK_FREQ_HZ / 1000000) * `IDLE_SUSPEND_US)

// Event counts and the number of endpoints.
`define MISS_LIMIT 3
`define LOCK_SOF_COUNT 2
`define NUM_EP 8

`endif

/* shared/usb_frame_pkg.sv */
`default_nettype none
package usb_frame_pkg;

	// State of the frame, status and address block.
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic sof_flag;
		logic miss_flag;
		logic l1_flag;
		logic [10:0] frame_num;
		logic lock;
		logic arm;
		logic [1:0] lock_cnt;
		logic [1:0] lost_cnt;
		logic [1:0] miss_run;
		logic [16:0] sof_tmr;
		logic [16:0] idle_tmr;
		logic func_en;
		logic [6:0] dev_addr;
		logic dp_s1;
		logic dp_s2;
		logic dm_s1;
		logic dm_s2;
		logic suspend_evt;
		logic tok_accept;
		logic [2:0] tok_index;
	} frame_state_t;

	// State of the endpoint picker.
	typedef struct packed {
		logic found;
		logic [3:0] source_endpoint_number;
		logic dir;
	} pick_state_t;

	// Index of the lowest set bit; zero when none is set.
	function automatic logic [2:0] lowest_set(input logic [7:0] m);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (m[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction : lowest_set

endpackage : usb_frame_pkg
`default_nettype wire

/* shared/ep_pick_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ep_pick_if;
	logic [7:0] tx_valid;
	logic [7:0] rx_valid;
	logic [7:0] prio;
	logic found;
	logic [3:0] source_endpoint_number;
	logic dir;

	modport source (output tx_valid, output rx_valid, output prio,
		input found, input source_endpoint_number, input dir);
	modport picker (input tx_valid, input rx_valid, input prio,
		output found, output source_endpoint_number, output dir);
endinterface : ep_pick_if
`default_nettype wire

/* logic/endpoint_pick.sv */
`timescale 1ns/1ps
`default_nettype none
module endpoint_pick (
	input wire logic clock_i, // System clock.
	input wire logic srst_i, // Synchronous reset, high.
	ep_pick_if.picker pick // Endpoint flags in, source out.
);
	import usb_frame_pkg::*;

	pick_state_t q;
	pick_state_t d;
	logic [7:0] pend;
	logic [7:0] hi;
	logic [2:0] sel;

	// Preferred endpoints win over the rest, lowest index within a group.
	always_comb begin
		d = q;
		pend = pick.tx_valid | pick.rx_valid;
		hi = pend & pick.prio;
		if (|hi) begin
			sel = lowest_set(hi);
		end else begin
			sel = lowest_set(pend);
		end
		d.found = |pend;
		d.source_endpoint_number = {1'b0, sel};
		d.dir = pick.rx_valid[sel];
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign pick.found = q.found;
	assign pick.source_endpoint_number = q.source_endpoint_number;
	assign pick.dir = q.dir;

	// Direction follows the receive flag of the reported endpoint.
	a_dir_follows_rx: assert property (@(posedge clock_i) disable iff (srst_i)
		pick.found |-> pick.dir ==
		(|($past(pick.rx_valid) & (8'h01 << pick.source_endpoint_number[2:0]))))
		else $error("direction bit does not match receive flag");

	// A preferred endpoint pending means a preferred one is reported.
	a_group_first: assert property (@(posedge clock_i) disable iff (srst_i)
		|($past(pick.prio) & ($past(pick.tx_valid) | $past(pick.rx_valid)))
		|-> (|($past(pick.prio) & (8'h01 << pick.source_endpoint_number[2:0]))))
		else $error("preferred endpoint group was skipped");

	// No pending endpoint of the reported group sits below it.
	a_lowest_wins: assert property (@(posedge clock_i) disable iff (srst_i)
		pick.found |-> ((($past(pick.tx_valid) | $past(pick.rx_valid)) &
		~($past(pick.prio) ^ {8{|($past(pick.prio) &
		(8'h01 << pick.source_endpoint_number[2:0]))}}) &
		((8'h01 << pick.source_endpoint_number[2:0]) - 8'h01)) == 8'h00))
		else $error("a lower pending endpoint was passed over");

endmodule : endpoint_pick
`default_nettype wire

/* logic/usb_frame_status_and_address.sv */
// Notes on behaviour
// - Received SOF sets the start-of-frame flag.
// - Missing expected SOF sets the missed-frame flag.
// - Three misses without traffic raise suspend event.
// - Misses are flagged even before frame lock.
// - Acknowledged L1 request sets the sleep flag; here only in device mode.
// - Writing zero clears flags; one leaves them.
// - Transmit-valid only reports direction zero.
// - Receive-valid pending reports direction one.
// - Report interrupting endpoint number in four bits.
// - Isochronous and double-buffered endpoints are preferred.
// - Within a group the lowest index wins.
// - Capture frame number on each SOF event.
// - Show plus and minus line levels.
// - Lock after two SOFs; drop on reset/suspend.
// - Count lost SOFs; clear on received SOF.
// - Function disabled means no transaction is handled.
// - Token address and endpoint must both match.
// - Host mode sends address field in LPM.
// - Three milliseconds without traffic raise suspend event.
`timescale 1ns/1ps
`default_nettype none
`include "usb_frame_defs.svh"
module usb_frame_status_and_address #(
	parameter logic [16:0] SOF_WAIT_CYCLES = 17'(`SOF_WAIT_CYC),
	parameter logic [16:0] IDLE_WAIT_CYCLES = 17'(`IDLE_WAIT_CYC)
) (
	input wire logic clock_i, // System clock, 25 MHz.
	input wire logic srst_i, // Synchronous reset, high.
	input wire logic [7:0] avs_address_i, // Avalon byte address.
	input wire logic avs_read_i, // Avalon read request.
	input wire logic avs_write_i, // Avalon write request.
	input wire logic [31:0] avs_writedata_i, // Avalon write data.
	input wire logic [3:0] avs_byteenable_i, // Avalon byte lanes.
	output logic [31:0] avs_readdata_o, // Avalon read data.
	output logic avs_waitrequest_o, // Avalon stall.
	input wire logic host_mode_i, // High in host mode.
	input wire logic sof_rx_i, // Pulse: good SOF received.
	input wire logic [10:0] sof_frame_i, // Frame number of that SOF.
	input wire logic bus_activity_i, // Pulse: other bus traffic.
	input wire logic usb_reset_i, // Pulse: end of USB reset.
	input wire logic resume_end_i, // Pulse: end of resume.
	input wire logic suspend_active_i, // Level: suspend mode on.
	input wire logic lpm_l1_ack_i, // Pulse: L1 request acked.
	input wire logic dp_i, // Plus data line pin.
	input wire logic dm_i, // Minus data line pin.
	input wire logic token_valid_i, // Pulse: token decoded.
	input wire logic [6:0] token_addr_i, // Token function address.
	input wire logic [3:0] token_ep_i, // Token endpoint number.
	input wire logic [7:0] ep_enable_i, // Endpoint in use.
	input wire logic [31:0] ep_addr_i, // Endpoint address fields.
	input wire logic [7:0] ep_prio_i, // Iso or double-buffered bulk.
	input wire logic [7:0] ep_tx_valid_i, // Transmit-valid flags.
	input wire logic [7:0] ep_rx_valid_i, // Receive-valid flags.
	output logic token_accept_o, // Pulse: token is for us.
	output logic [2:0] token_ep_index_o, // Register index of match.
	output logic [6:0] lpm_target_addr_o, // Address for LPM in host.
	output logic suspend_req_o // Pulse: suspend requested.
);
	import usb_frame_pkg::*;

	frame_state_t q;
	frame_state_t d;
	logic req;
	logic wr_now;
	logic wr_irq;
	logic wr_addr;
	logic miss_evt;
	logic idle_evt;
	logic tmr_run;
	logic [7:0] ep_hit;
	logic [31:0] irq_word;
	logic [31:0] fnr_word;
	logic [31:0] daddr_word;

	ep_pick_if pick_bus ();

	// The picker looks only at the valid flags and the preference mask.
	assign pick_bus.tx_valid = ep_tx_valid_i;
	assign pick_bus.rx_valid = ep_rx_valid_i;
	assign pick_bus.prio = ep_prio_i;

	endpoint_pick u_pick (
		.clock_i(clock_i),
		.srst_i(srst_i),
		.pick(pick_bus)
	);

	// Endpoint address compare, one comparator per endpoint register.
	for (genvar i = 0; i < `NUM_EP; i++) begin : g_ep_hit
		assign ep_hit[i] = ep_enable_i[i] &&
			(ep_addr_i[i * 4 +: 4] == token_ep_i);
	end

	// Read images of the three words; unused bits read as zero.
	always_comb begin
		irq_word = 32'h0000_0000;
		irq_word[`IRQ_SOF_BIT] = q.sof_flag;
		irq_word[`IRQ_MISS_BIT] = q.miss_flag;
		irq_word[`IRQ_L1_BIT] = q.l1_flag;
		irq_word[`IRQ_DIR_BIT] = pick_bus.dir;
		irq_word[3:0] = pick_bus.source_endpoint_number;
		fnr_word = {16'h0000, q.dp_s2, q.dm_s2, q.lock, q.lost_cnt,
			q.frame_num};
		daddr_word = {24'h00_0000, q.func_en, q.dev_addr};
	end

	// The slave answers every request on its second cycle, so a write
	// lands and read data stand exactly at the edge without waitrequest.
	assign req = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = req & ~q.ack;
	assign wr_now = avs_write_i & q.ack;
	assign wr_irq = wr_now && (avs_address_i == `OFS_IRQ_STATUS);
	assign wr_addr = wr_now && (avs_address_i == `OFS_DEV_ADDR);
	assign tmr_run = ~suspend_active_i & ~host_mode_i;

	// Next-state logic for everything the block remembers.
	always_comb begin
		d = q;
		miss_evt = 1'b0;
		idle_evt = 1'b0;
		d.suspend_evt = 1'b0;

		// Bus handshake and read data capture one cycle before the answer.
		d.ack = req & ~q.ack;
		if (avs_read_i && !q.ack) begin
			case (avs_address_i)
				`OFS_IRQ_STATUS: d.rdata = irq_word;
				`OFS_FRAME_NUMBER: d.rdata = fnr_word;
				`OFS_DEV_ADDR: d.rdata = daddr_word;
				default: d.rdata = 32'h0000_0000;
			endcase
		end

		// Software clears flags with zeros; ones leave them untouched.
		if (wr_irq && avs_byteenable_i[1]) begin
			if (!avs_writedata_i[`IRQ_SOF_BIT]) begin
				d.sof_flag = 1'b0;
			end
			if (!avs_writedata_i[`IRQ_MISS_BIT]) begin
				d.miss_flag = 1'b0;
			end
		end
		if (wr_irq && avs_byteenable_i[0]) begin
			if (!avs_writedata_i[`IRQ_L1_BIT]) begin
				d.l1_flag = 1'b0;
			end
		end

		// Address and enable are plain storage in the low byte.
		if (wr_addr && avs_byteenable_i[0]) begin
			d.func_en = avs_writedata_i[`DADDR_EF_BIT];
			d.dev_addr = avs_writedata_i[6:0];
		end

		// Line levels come from pins, so they pass two flops first.
		d.dp_s1 = dp_i;
		d.dp_s2 = q.dp_s1;
		d.dm_s1 = dm_i;
		d.dm_s2 = q.dm_s1;

		// Interval timer: every SOF restarts it, so SOFs arriving on time
		// never let it reach the end of the interval.
		if (sof_rx_i) begin
			d.sof_tmr = 17'h0_0000;
		end else if (tmr_run) begin
			if (q.sof_tmr == SOF_WAIT_CYCLES - 17'h0_0001) begin
				miss_evt = 1'b1;
				d.sof_tmr = 17'h0_0000;
			end else begin
				d.sof_tmr = q.sof_tmr + 17'h0_0001;
			end
		end

		// Idle timer sees any traffic, SOFs included.
		if (sof_rx_i || bus_activity_i) begin
			d.idle_tmr = 17'h0_0000;
		end else if (tmr_run) begin
			if (q.idle_tmr == IDLE_WAIT_CYCLES - 17'h0_0001) begin
				idle_evt = 1'b1;
				d.idle_tmr = 17'h0_0000;
			end else begin
				d.idle_tmr = q.idle_tmr + 17'h0_0001;
			end
		end

		// A miss bumps the lost count and the run of misses; the flag is
		// set regardless of lock, and set beats a clear in this cycle.
		if (miss_evt) begin
			d.miss_flag = 1'b1;
			d.lost_cnt = q.lost_cnt + 2'h1;
			if (q.miss_run == 2'(`MISS_LIMIT - 1)) begin
				d.suspend_evt = 1'b1;
				d.miss_run = 2'h0;
			end else begin
				d.miss_run = q.miss_run + 2'h1;
			end
			if (q.arm) begin
				d.lock_cnt = 2'h0;
			end
		end
		if (bus_activity_i && !miss_evt) begin
			d.miss_run = 2'h0;
		end
		if (idle_evt) begin
			d.suspend_evt = 1'b1;
		end

		// A received SOF raises its flag and captures the frame number.
		if (sof_rx_i) begin
			d.sof_flag = 1'b1;
			d.frame_num = sof_frame_i;
			d.lost_cnt = 2'h0;
			d.miss_run = 2'h0;
			if (q.arm) begin
				if (q.lock_cnt == 2'(`LOCK_SOF_COUNT - 1)) begin
					d.lock = 1'b1;
					d.arm = 1'b0;
				end else begin
					d.lock_cnt = q.lock_cnt + 2'h1;
				end
			end
		end

		// Lock is dropped by reset or suspend and rearmed by reset or
		// resume; a resume while still locked keeps the lock as it is.
		if (suspend_active_i) begin
			d.lock = 1'b0;
			d.arm = 1'b0;
		end
		if (resume_end_i && !q.lock) begin
			d.arm = 1'b1;
			d.lock_cnt = 2'h0;
		end
		if (usb_reset_i) begin
			d.lock = 1'b0;
			d.arm = 1'b1;
			d.lock_cnt = 2'h0;
			d.miss_run = 2'h0;
		end

		// The L1 flag is a device-mode event only.
		if (lpm_l1_ack_i && !host_mode_i) begin
			d.l1_flag = 1'b1;
		end

		// Token match needs the function enabled, our address and an
		// endpoint whose address field equals the token endpoint.
		d.tok_accept = token_valid_i && q.func_en && !host_mode_i &&
			(token_addr_i == q.dev_addr) && (|ep_hit);
		d.tok_index = lowest_set(ep_hit);
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Outputs other than waitrequest all come straight from state.
	assign avs_readdata_o = q.rdata;
	assign token_accept_o = q.tok_accept;
	assign token_ep_index_o = q.tok_index;
	assign lpm_target_addr_o = q.dev_addr;
	assign suspend_req_o = q.suspend_evt;

	// An SOF always leaves its flag set, even against a clearing write.
	a_sof_sets_flag: assert property (@(posedge clock_i) disable iff (srst_i)
		sof_rx_i |=> q.sof_flag)
		else $error("SOF did not set its flag");

	// The frame field holds the number carried by the last SOF.
	a_frame_capture: assert property (@(posedge clock_i) disable iff (srst_i)
		sof_rx_i |=> q.frame_num == $past(sof_frame_i) && q.lost_cnt == 2'h0)
		else $error("frame number or lost count wrong after SOF");

	// A miss fires only at the end of a full interval since the last SOF or miss.
	a_miss_interval: assert property (@(posedge clock_i) disable iff (srst_i)
		miss_evt |-> q.sof_tmr == SOF_WAIT_CYCLES - 17'h0_0001 && !sof_rx_i
		##1 q.miss_flag)
		else $error("missed-frame event at wrong time");

	// Each miss advances the lost SOF count by one.
	a_lost_count: assert property (@(posedge clock_i) disable iff (srst_i)
		miss_evt |=> q.lost_cnt == $past(q.lost_cnt) + 2'h1)
		else $error("lost count did not advance");

	// The third miss in a row without traffic asks for suspend.
	a_third_miss: assert property (@(posedge clock_i) disable iff (srst_i)
		miss_evt && q.miss_run == 2'h2 && !usb_reset_i |=> suspend_req_o)
		else $error("no suspend after third missed frame");

	// Writing one leaves a set flag alone.
	a_write_one_keeps: assert property (@(posedge clock_i)
		disable iff (srst_i)
		wr_irq && avs_writedata_i[`IRQ_MISS_BIT] && q.miss_flag
		|=> q.miss_flag)
		else $error("writing one cleared a flag");

	// A clearing write with no new event drops the flag.
	a_write_zero_clears: assert property (@(posedge clock_i)
		disable iff (srst_i)
		wr_irq && avs_byteenable_i[0] && !avs_writedata_i[`IRQ_L1_BIT] &&
		!lpm_l1_ack_i |=> !q.l1_flag)
		else $error("writing zero left the L1 flag set");

	// An acknowledged L1 request in device mode sets the flag.
	a_l1_sets_flag: assert property (@(posedge clock_i) disable iff (srst_i)
		lpm_l1_ack_i && !host_mode_i |=> q.l1_flag)
		else $error("L1 request flag not set");

	// With the function disabled no token is ever accepted.
	a_func_gate: assert property (@(posedge clock_i) disable iff (srst_i)
		!q.func_en |=> !token_accept_o)
		else $error("token accepted while function disabled");

	// After a USB reset, lock needs two further SOFs.
	a_lock_after_two: assert property (@(posedge clock_i) disable iff (srst_i)
		usb_reset_i |=> !q.lock ##1 (!q.lock || $past(sof_rx_i)))
		else $error("lock state wrong after USB reset");

endmodule : usb_frame_status_and_address
`default_nettype wire

/* sim/usb_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Far-side host: drives bus events as pulses just after rising edges.
module usb_host_model (
	input wire logic clock_i, // System clock.
	output logic sof_rx_o, // Good SOF pulse.
	output logic [10:0] sof_frame_o, // Frame number with the SOF.
	output logic activity_o, // Other traffic pulse.
	output logic reset_end_o, // End of USB reset pulse.
	output logic resume_o, // End of resume pulse.
	output logic suspend_o, // Suspend mode level.
	output logic l1_ack_o, // L1 request acked pulse.
	output logic dp_o, // Plus data line.
	output logic dm_o, // Minus data line.
	output logic tok_valid_o, // Token decoded pulse.
	output logic [6:0] tok_addr_o, // Token function address.
	output logic [3:0] tok_ep_o // Token endpoint number.
);
	// The idle bus sits in the J state with the plus line high.
	initial begin
		{sof_rx_o, activity_o, reset_end_o, suspend_o, l1_ack_o} = 5'h00;
		resume_o = 1'b0;
		{tok_valid_o, tok_addr_o, tok_ep_o, sof_frame_o} = '0;
		dp_o = 1'b1;
		dm_o = 1'b0;
	end

	// Fields are inverted once their pulse ends, so a stale value never
	// looks like a fresh one.
	task sof(input logic [10:0] n);
		@(posedge clock_i);
		sof_rx_o <= 1'b1;
		sof_frame_o <= n;
		@(posedge clock_i);
		sof_rx_o <= 1'b0;
		sof_frame_o <= ~n;
	endtask : sof

	task token(input logic [6:0] a, input logic [3:0] e);
		@(posedge clock_i);
		tok_valid_o <= 1'b1;
		tok_addr_o <= a;
		tok_ep_o <= e;
		@(posedge clock_i);
		tok_valid_o <= 1'b0;
		tok_addr_o <= ~a;
		tok_ep_o <= ~e;
	endtask : token

	// Kind 0 is traffic, 1 is end of reset, 2 is an acked L1 request,
	// and any other kind is the end of a resume.
	task strobe(input int k);
		@(posedge clock_i);
		case (k)
			0: activity_o <= 1'b1;
			1: reset_end_o <= 1'b1;
			2: l1_ack_o <= 1'b1;
			default: resume_o <= 1'b1;
		endcase
		@(posedge clock_i);
		{activity_o, reset_end_o, l1_ack_o, resume_o} <= 4'h0;
	endtask : strobe

	task suspend(input logic v);
		@(posedge clock_i);
		suspend_o <= v;
	endtask : suspend

	task lines(input logic p, input logic m);
		@(posedge clock_i);
		dp_o <= p;
		dm_o <= m;
	endtask : lines
endmodule : usb_host_model
`default_nettype wire

/* sim/tb_usb_frame_status_and_address.sv */
`timescale 1ns/1ps
`default_nettype none
`include "usb_frame_defs.svh"
module tb_usb_frame_status_and_address;
	logic clock_i = 1'b0;
	logic srst_i = 1'b1;
	logic [7:0] avs_address_i = 8'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0000_0000;
	logic [3:0] avs_byteenable_i = 4'hF;
	logic host_mode_i = 1'b0;
	logic [7:0] ep_enable_i = 8'h00;
	logic [31:0] ep_addr_i = 32'h0000_0000;
	logic [7:0] ep_prio_i = 8'h00;
	logic [7:0] ep_tx_valid_i = 8'h00;
	logic [7:0] ep_rx_valid_i = 8'h00;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o, token_accept_o, suspend_req_o;
	logic [2:0] token_ep_index_o;
	logic [6:0] lpm_target_addr_o;
	logic sof_rx, activity, reset_end, suspend, l1_ack, dp, dm, tok_valid;
	logic resume;
	logic [10:0] sof_frame;
	logic [6:0] tok_addr;
	logic [3:0] tok_ep;
	int bad_count = 0;
	int total_checks = 0;
	int suspend_request_flag_seen = 0;
	int base;
	logic [31:0] rd;
	// Pending-endpoint cases: transmit, receive, priority, expected dir/idn.
	logic [7:0] t_tx [6] = '{8'h04, 8'h00, 8'h20, 8'h0A, 8'h82, 8'h40};
	logic [7:0] t_rx [6] = '{8'h00, 8'h08, 8'h20, 8'h00, 8'h00, 8'h10};
	logic [7:0] t_pr [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h50};
	logic [4:0] t_ex [6] = '{5'h02, 5'h13, 5'h15, 5'h01, 5'h07, 5'h14};

	usb_frame_status_and_address #(.SOF_WAIT_CYCLES(17'd20),
		.IDLE_WAIT_CYCLES(17'd70)) dut (.clock_i(clock_i), .srst_i(srst_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .host_mode_i(host_mode_i),
		.sof_rx_i(sof_rx), .sof_frame_i(sof_frame), .bus_activity_i(activity),
		.usb_reset_i(reset_end), .resume_end_i(resume),
		.suspend_active_i(suspend), .lpm_l1_ack_i(l1_ack), .dp_i(dp),
		.dm_i(dm), .token_valid_i(tok_valid), .token_addr_i(tok_addr),
		.token_ep_i(tok_ep), .ep_enable_i(ep_enable_i), .ep_addr_i(ep_addr_i),
		.ep_prio_i(ep_prio_i), .ep_tx_valid_i(ep_tx_valid_i),
		.ep_rx_valid_i(ep_rx_valid_i), .token_accept_o(token_accept_o),
		.token_ep_index_o(token_ep_index_o),
		.lpm_target_addr_o(lpm_target_addr_o), .suspend_req_o(suspend_req_o));

	usb_host_model host (.clock_i(clock_i), .sof_rx_o(sof_rx),
		.sof_frame_o(sof_frame), .activity_o(activity),
		.reset_end_o(reset_end), .resume_o(resume), .suspend_o(suspend),
		.l1_ack_o(l1_ack),
		.dp_o(dp), .dm_o(dm), .tok_valid_o(tok_valid), .tok_addr_o(tok_addr),
		.tok_ep_o(tok_ep));

	// Clock of 40 ns period.
	always #20 clock_i = ~clock_i;

	// Suspend requests are counted, so pulse width and number both show.
	always @(posedge clock_i) begin
		if (suspend_req_o === 1'b1) begin
			suspend_request_flag_seen <= suspend_request_flag_seen + 1;
		end
	end

	task end_sim;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_sim

	task check(input string s, input logic [31:0] got, input logic [31:0] e);
		total_checks++;
		if (got !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", s, e, got);
		end
	endtask : check

	// One Avalon transfer; the request holds until waitrequest is seen low.
	task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock_i);
		avs_address_i <= a;
		avs_writedata_i <= wd;
		avs_write_i <= wr;
		avs_read_i <= ~wr;
		do begin
			@(posedge clock_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 20);
		d = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		if (n >= 20) begin
			check("waitrequest", 32'h0000_0001, 32'h0000_0000);
		end
	endtask : xfer

	task wr(input logic [7:0] a, input logic [31:0] wd);
		xfer(1'b1, a, wd, rd);
	endtask : wr

	task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input string s);
		xfer(1'b0, a, 32'h0000_0000, rd);
		check(s, rd & m, e);
	endtask : rchk

	// A token is judged in the single cycle that its accept pulse stands.
	task tok(input logic [6:0] a, input logic [3:0] e, input logic acc,
		input logic [2:0] idx);
		host.token(a, e);
		#1;
		check("accept", {31'h0, token_accept_o}, {31'h0, acc});
		if (acc) begin
			check("index", {29'h0, token_ep_index_o}, {29'h0, idx});
		end
	endtask : tok

	// Watchdog well beyond the few hundred cycles that the tests need.
	initial begin
		repeat (20000) @(posedge clock_i);
		bad_count++;
		end_sim();
	end

	initial begin
		repeat (3) @(posedge clock_i);
		srst_i <= 1'b0;
		rchk(`OFS_DEV_ADDR, 32'hFFFF_FFFF, `DADDR_RESET, "daddr");
		rchk(8'h50, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
		ep_enable_i <= 8'h24;
		ep_addr_i <= 32'h0030_0330;
		tok(7'h05, 4'h3, 1'b0, 3'h0);
		wr(8'h50, 32'hFFFF_FFFF);
		wr(`OFS_DEV_ADDR, 32'hFFFF_FF85);
		avs_byteenable_i <= 4'hE;
		wr(`OFS_DEV_ADDR, 32'h0000_0000);
		avs_byteenable_i <= 4'hF;
		rchk(`OFS_DEV_ADDR, 32'hFFFF_FFFF, 32'h0000_0085, "daddr");
		tok(7'h05, 4'h3, 1'b1, 3'h2);
		tok(7'h06, 4'h3, 1'b0, 3'h0);
		tok(7'h05, 4'h4, 1'b0, 3'h0);
		ep_enable_i <= 8'h26;
		tok(7'h05, 4'h3, 1'b1, 3'h1);
		host_mode_i <= 1'b1;
		tok(7'h05, 4'h3, 1'b0, 3'h0);
		check("lpm addr", {25'h0, lpm_target_addr_o}, 32'h0000_0005);
		host_mode_i <= 1'b0;
		// Endpoint source picking, direction and number.
		for (int i = 0; i < 6; i++) begin
			ep_tx_valid_i <= t_tx[i];
			ep_rx_valid_i <= t_rx[i];
			ep_prio_i <= t_pr[i];
			@(posedge clock_i);
			xfer(1'b0, `OFS_IRQ_STATUS, 32'h0000_0000, rd);
			check("dir", rd & 32'h0000_0070, 32'(t_ex[i][4]) << 4);
			check("idn", rd & 32'h0000_000F, 32'(t_ex[i][3:0]));
		end
		// Frames were missed since reset while no lock was held.
		rchk(`OFS_IRQ_STATUS, 32'h0000_0100, 32'h0000_0100, "miss");
		host.strobe(1);
		host.sof(11'h123);
		rchk(`OFS_FRAME_NUMBER, 32'hFFFF_FFFF, 32'h0000_8123, "fnr");
		rchk(`OFS_IRQ_STATUS, 32'h0000_0200, 32'h0000_0200, "sof");
		host.sof(11'h124);
		rchk(`OFS_FRAME_NUMBER, 32'hFFFF_FFFF, 32'h0000_A124, "lock");
		wr(`OFS_IRQ_STATUS, 32'h0000_0000);
		for (int i = 0; i < 3; i++) begin
			host.sof(11'h125 + 11'(i));
			repeat (10) @(posedge clock_i);
		end
		rchk(`OFS_IRQ_STATUS, 32'h0000_0300, 32'h0000_0200, "on time");
		// SOFs stop: misses every 20 cycles, suspend after the third.
		host.sof(11'h200);
		base = suspend_request_flag_seen;
		repeat (46) @(posedge clock_i);
		check("suspend", 32'(suspend_request_flag_seen - base), 32'h0000_0000);
		rchk(`OFS_FRAME_NUMBER, 32'h0000_1800, 32'h0000_1000, "lost");
		repeat (18) @(posedge clock_i);
		check("suspend", 32'(suspend_request_flag_seen - base), 32'h0000_0001);
		rchk(`OFS_FRAME_NUMBER, 32'h0000_1800, 32'h0000_1800, "lost");
		repeat (8) @(posedge clock_i);
		check("idle", 32'(suspend_request_flag_seen - base), 32'h0000_0002);
		host.suspend(1'b1);
		rchk(`OFS_FRAME_NUMBER, 32'h0000_2000, 32'h0000_0000, "unlock");
		host_mode_i <= 1'b1;
		host.strobe(2);
		rchk(`OFS_IRQ_STATUS, 32'h0000_0080, 32'h0000_0000, "l1 host");
		host_mode_i <= 1'b0;
		host.strobe(2);
		rchk(`OFS_IRQ_STATUS, 32'h0000_0080, 32'h0000_0080, "l1");
		// Ones leave the flags alone; zeros clear the SOF flag first, then the other two together.
		wr(`OFS_IRQ_STATUS, 32'h0000_FFFF);
		rchk(`OFS_IRQ_STATUS, 32'h0000_0380, 32'h0000_0380, "w1");
		wr(`OFS_IRQ_STATUS, 32'hFFFF_FDFF);
		rchk(`OFS_IRQ_STATUS, 32'h0000_0380, 32'h0000_0180, "w0");
		wr(`OFS_IRQ_STATUS, 32'h0000_0000);
		rchk(`OFS_IRQ_STATUS, 32'h0000_0380, 32'h0000_0000, "w0");
		host.lines(1'b0, 1'b1);
		repeat (3) @(posedge clock_i);
		rchk(`OFS_FRAME_NUMBER, 32'h0000_C000, 32'h0000_4000, "lines");
		// Leaving suspend, a resume rearms lock; one SOF is not enough.
		host.suspend(1'b0);
		host.strobe(3);
		host.sof(11'h300);
		rchk(`OFS_FRAME_NUMBER, 32'h0000_27FF, 32'h0000_0300, "one sof");
		host.sof(11'h301);
		rchk(`OFS_FRAME_NUMBER, 32'h0000_27FF, 32'h0000_2301, "resume");
		end_sim();
	end
endmodule : tb_usb_frame_status_and_address
`default_nettype wire
